/* File: verilog/exec_pkg.sv */
package exec_pkg;
    // ****************************************************************
    // Operation encodings
    // ****************************************************************
    localparam logic [3:0] OP_AND = 4'h0;
    localparam logic [3:0] OP_XOR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_RSUB = 4'h3;
    localparam logic [3:0] OP_ADD = 4'h4;
    localparam logic [3:0] OP_ADC = 4'h5;
    localparam logic [3:0] OP_SBW = 4'h6;
    localparam logic [3:0] OP_RSBW = 4'h7;
    localparam logic [3:0] OP_TST = 4'h8;
    localparam logic [3:0] OP_TEQ = 4'h9;
    localparam logic [3:0] OP_CMP = 4'hA;
    localparam logic [3:0] OP_CMN = 4'hB;
    localparam logic [3:0] OP_OR = 4'hC;
    localparam logic [3:0] OP_MOV = 4'hD;
    localparam logic [3:0] OP_BIC = 4'hE;
    localparam logic [3:0] OP_MVN = 4'hF;

    // ****************************************************************
    // Condition codes
    // ****************************************************************
    localparam logic [3:0] CC_EQ = 4'h0;
    localparam logic [3:0] CC_NE = 4'h1;
    localparam logic [3:0] CC_CS = 4'h2;
    localparam logic [3:0] CC_CC = 4'h3;
    localparam logic [3:0] CC_MI = 4'h4;
    localparam logic [3:0] CC_PL = 4'h5;
    localparam logic [3:0] CC_VS = 4'h6;
    localparam logic [3:0] CC_VC = 4'h7;
    localparam logic [3:0] CC_HI = 4'h8;
    localparam logic [3:0] CC_LS = 4'h9;
    localparam logic [3:0] CC_GE = 4'hA;
    localparam logic [3:0] CC_LT = 4'hB;
    localparam logic [3:0] CC_GT = 4'hC;
    localparam logic [3:0] CC_LE = 4'hD;
    localparam logic [3:0] CC_AL = 4'hE;

    // ****************************************************************
    // Registers, field positions, reset values
    // ****************************************************************
    localparam logic [3:0] REG_RETURN = 4'hE;
    localparam logic [3:0] REG_PC = 4'hF;
    localparam int BIT_IMM_SEL = 25;
    localparam int BIT_SET_FLAGS = 20;
    localparam int COND_HI = 31;
    localparam int COND_LO = 28;
    localparam logic [31:0] INSN_STEP = 32'h0000_0004;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    typedef enum {
        K_NONE,
        K_DATA,
        K_BRANCH,
        K_EXCHANGE,
        K_LOAD_PC,
        K_MUL,
        K_MUL_LONG
    } kind_e;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_s;

    typedef struct packed {
        logic valid;
        logic [2:0] kind;
        logic [31:0] insn;
        logic [31:0] pc;
        logic [31:0] op_first;
        logic [31:0] op_shift;
        logic shift_carry;
        logic [31:0] op_imm;
        logic [31:0] op_acc_lo;
        logic [31:0] op_acc_hi;
        logic [3:0] rd;
        logic [3:0] rd_hi;
        logic mul_acc;
        logic mul_signed;
    } issue_s;

    typedef struct packed {
        logic we_lo;
        logic [3:0] rd_lo;
        logic [31:0] data_lo;
        logic we_hi;
        logic [3:0] rd_hi;
        logic [31:0] data_hi;
    } wb_s;
endpackage : exec_pkg

/* File: verilog/branch_alu_multiply_exec.sv */
// How it works
// - Conditional relative branch reaching thirty-two megabytes
// - Writing register fifteen redirects the program
// - Linking branch saves next address in fourteen
// - Loaded word goes straight into program counter
// - Exchange branch jumps, may switch compact set
// - Opcodes 0100/0101 add, add with carry
// - Opcodes 0010/0110 subtract, subtract with borrow
// - Opcodes 0011/0111 reverse subtract, with borrow
// - Opcodes 0000/0001/1100 AND, XOR, OR
// - Opcode 1110 clears bits set in operand
// - Opcodes 1101/1111 move, move inverted
// - Opcodes 1010/1011 compare, flags only
// - Opcodes 1000/1001 test, flags only
// - Bit 25 picks immediate or shifted register
// - Bit 20 sets flags; compares always
// - Negative and zero follow the result
// - Carry from adder or from shifter
// - Overflow from arithmetic, kept by logicals
// - Low product word, optional accumulate
// - Short multiplies sign-blind, optional N Z
// - Long product signed or unsigned, two halves
// - Long accumulate adds destination pair back
// - Condition field gates every operation
// - Flags held in current status word
`timescale 1ns/1ns
module branch_alu_multiply_exec
    import exec_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire issue_s issue,
    input wire logic [31:0] load_data,
    output wb_s wb,
    output flags_s current_status_word,
    output logic compact_mode,
    output logic redirect,
    output logic [31:0] redirect_target,
    output logic executed
);

    // ****************************************************************
    // Condition check
    // ****************************************************************
    function automatic logic cond_pass(input logic [3:0] cc, input flags_s f);
        logic r;
        r = 1'b0;
        unique case (cc)
            CC_EQ: r = f.z;
            CC_NE: r = !f.z;
            CC_CS: r = f.c;
            CC_CC: r = !f.c;
            CC_MI: r = f.n;
            CC_PL: r = !f.n;
            CC_VS: r = f.v;
            CC_VC: r = !f.v;
            CC_HI: r = f.c && !f.z;
            CC_LS: r = !f.c || f.z;
            CC_GE: r = (f.n == f.v);
            CC_LT: r = (f.n != f.v);
            CC_GT: r = !f.z && (f.n == f.v);
            CC_LE: r = f.z || (f.n != f.v);
            CC_AL: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : cond_pass

    // Adder shared by all arithmetic; b arrives already inverted for subtraction
    function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b, input logic cin);
        return {1'b0, a} + {1'b0, b} + {32'h0, cin};
    endfunction : add33

    flags_s flags;
    logic mode_compact;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire [3:0] cond = issue.insn[COND_HI:COND_LO];
    wire [3:0] opcode = issue.insn[24:21];
    wire set_bit = issue.insn[BIT_SET_FLAGS];
    wire go = issue.valid && cond_pass(cond, flags);
    wire is_data = go && (issue.kind == 3'(K_DATA));
    wire is_branch = go && (issue.kind == 3'(K_BRANCH));
    wire is_exch = go && (issue.kind == 3'(K_EXCHANGE));
    wire is_load_pc = go && (issue.kind == 3'(K_LOAD_PC));
    wire is_mul = go && (issue.kind == 3'(K_MUL));
    wire is_mull = go && (issue.kind == 3'(K_MUL_LONG));

    // Second operand: immediate or shifted register
    wire [31:0] op_b = issue.insn[BIT_IMM_SEL] ? issue.op_imm : issue.op_shift;
    wire [31:0] op_a = issue.op_first;
    wire compare_class = (opcode[3:2] == 2'b10);

    // ****************************************************************
    // Arithmetic and logic
    // ****************************************************************
    wire sub_form = (opcode == OP_SUB) || (opcode == OP_SBW) || (opcode == OP_CMP);
    wire rsub_form = (opcode == OP_RSUB) || (opcode == OP_RSBW);
    wire use_carry = (opcode == OP_ADC) || (opcode == OP_SBW) || (opcode == OP_RSBW);
    wire [31:0] add_x = rsub_form ? op_b : op_a;
    wire [31:0] add_y_raw = rsub_form ? op_a : op_b;
    wire [31:0] add_y = (sub_form || rsub_form) ? ~add_y_raw : add_y_raw;
    // Borrow form: x + ~y + C, so a clear carry subtracts one more
    wire add_cin = use_carry ? flags.c : (sub_form || rsub_form);
    wire [32:0] sum = add33(add_x, add_y, add_cin);
    wire add_ovf = (add_x[31] == add_y[31]) && (sum[31] != add_x[31]);
    wire is_arith = !opcode[3] ? opcode[2] | opcode[1] : (opcode[3:1] == 3'b101);

    logic [31:0] alu_res;
    always_comb begin
        unique case (opcode)
            OP_AND, OP_TST: alu_res = op_a & op_b;
            OP_XOR, OP_TEQ: alu_res = op_a ^ op_b;
            OP_OR: alu_res = op_a | op_b;
            OP_BIC: alu_res = op_a & ~op_b;
            OP_MOV: alu_res = op_b;
            OP_MVN: alu_res = ~op_b;
            default: alu_res = sum[31:0];
        endcase
    end

    wire dp_flags = is_data && (set_bit || compare_class);
    wire dp_write = is_data && !compare_class;
    // Immediates carry no shifter carry from the front end; keep C then
    wire shifter_c = issue.insn[BIT_IMM_SEL] ? flags.c : issue.shift_carry;

    // ****************************************************************
    // Multiply
    // ****************************************************************
    wire [63:0] prod_u = {32'h0, issue.op_first} * {32'h0, issue.op_shift};
    wire signed [63:0] prod_s = $signed({{32{issue.op_first[31]}}, issue.op_first})
        * $signed({{32{issue.op_shift[31]}}, issue.op_shift});
    wire [63:0] prod = issue.mul_signed ? 64'(prod_s) : prod_u;
    wire [31:0] mul_lo = prod[31:0] + (issue.mul_acc ? issue.op_acc_lo : 32'h0);
    wire [63:0] mull_res = prod + (issue.mul_acc ? {issue.op_acc_hi, issue.op_acc_lo} : 64'h0);
    wire mul_flags = (is_mul || is_mull) && set_bit;

    // ****************************************************************
    // Branches
    // ****************************************************************
    // 24-bit word offset gives plus or minus 32 Mbytes of reach
    wire [31:0] rel_off = {{6{issue.insn[23]}}, issue.insn[23:0], 2'b00};
    wire [31:0] rel_target = issue.pc + rel_off;
    wire link = issue.insn[24];
    wire [31:0] next_insn = issue.pc + INSN_STEP;

    // Result destined for register fifteen redirects the flow
    wire dp_to_pc = dp_write && (issue.rd == REG_PC);
    wire mul_to_pc = is_mul && (issue.rd == REG_PC);
    wire mull_lo_pc = is_mull && (issue.rd == REG_PC);
    wire mull_hi_pc = is_mull && (issue.rd_hi == REG_PC);

    logic next_redirect;
    logic [31:0] next_target;
    always_comb begin
        next_redirect = 1'b1;
        next_target = 32'h0;
        if (is_branch) begin
            next_target = rel_target;
        end else if (is_exch) begin
            next_target = {issue.op_shift[31:1], 1'b0};
        end else if (is_load_pc) begin
            next_target = load_data;
        end else if (dp_to_pc) begin
            next_target = alu_res;
        end else if (mul_to_pc) begin
            next_target = mul_lo;
        end else if (mull_hi_pc) begin
            next_target = mull_res[63:32];
        end else if (mull_lo_pc) begin
            next_target = mull_res[31:0];
        end else begin
            next_redirect = 1'b0;
        end
    end

    // ****************************************************************
    // Write-back
    // ****************************************************************
    wb_s next_wb;
    always_comb begin
        next_wb = '0;
        if (dp_write) begin
            next_wb.we_lo = 1'b1;
            next_wb.rd_lo = issue.rd;
            next_wb.data_lo = alu_res;
        end else if (is_branch && link) begin
            next_wb.we_lo = 1'b1;
            next_wb.rd_lo = REG_RETURN;
            next_wb.data_lo = next_insn;
        end else if (is_mul) begin
            next_wb.we_lo = 1'b1;
            next_wb.rd_lo = issue.rd;
            next_wb.data_lo = mul_lo;
        end else if (is_mull) begin
            next_wb.we_lo = 1'b1;
            next_wb.rd_lo = issue.rd;
            next_wb.data_lo = mull_res[31:0];
            next_wb.we_hi = 1'b1;
            next_wb.rd_hi = issue.rd_hi;
            next_wb.data_hi = mull_res[63:32];
        end else if (is_load_pc) begin
            next_wb.we_lo = 1'b1;
            next_wb.rd_lo = REG_PC;
            next_wb.data_lo = load_data;
        end
    end

    // ****************************************************************
    // Flags
    // ****************************************************************
    flags_s next_flags;
    always_comb begin
        next_flags = flags;
        if (dp_flags) begin
            next_flags.n = alu_res[31];
            next_flags.z = (alu_res == 32'h0);
            next_flags.c = is_arith ? sum[32] : shifter_c;
            next_flags.v = is_arith ? add_ovf : flags.v;
        end else if (mul_flags && is_mul) begin
            next_flags.n = mul_lo[31];
            next_flags.z = (mul_lo == 32'h0);
        end else if (mul_flags) begin
            next_flags.n = mull_res[63];
            next_flags.z = (mull_res == 64'h0);
        end
    end

    // Exchange picks the compact set from the target's low bit
    wire next_compact = is_exch ? issue.op_shift[0] : mode_compact;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= FLAGS_RESET;
            mode_compact <= 1'b0;
        end else begin
            flags <= next_flags;
            mode_compact <= next_compact;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb <= '0;
            redirect <= 1'b0;
            redirect_target <= 32'h0;
            executed <= 1'b0;
        end else begin
            wb <= next_wb;
            redirect <= next_redirect;
            redirect_target <= next_target;
            executed <= go;
        end
    end

    assign current_status_word = flags;
    assign compact_mode = mode_compact;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_failed_cond;
        issue.valid && !cond_pass(cond, flags);
    endsequence

    a_cond_blocks_write: assert property (s_failed_cond |=> !wb.we_lo && !redirect)
        else $error("Write on failed condition");
    a_branch_target: assert property (is_branch |=> redirect && redirect_target == $past(rel_target))
        else $error("Branch target wrong");
    a_link_saves: assert property (is_branch && link |=> wb.rd_lo == REG_RETURN && wb.data_lo == $past(next_insn))
        else $error("Link address wrong");
    a_pc_write_redirects: assert property (dp_to_pc |=> redirect && redirect_target == wb.data_lo)
        else $error("PC write no redirect");
    a_compare_no_write: assert property (is_data && compare_class |=> !wb.we_lo)
        else $error("Compare wrote register");
    a_zero_flag: assert property (dp_flags |=> current_status_word.z == ($past(alu_res) == 32'h0))
        else $error("Zero flag wrong");
    a_logic_keeps_v: assert property (dp_flags && !is_arith |=> $stable(current_status_word.v))
        else $error("Logical changed overflow");
    a_no_s_keeps_flags: assert property (is_data && !set_bit && !compare_class |=> $stable(current_status_word))
        else $error("Flags changed without set");
    a_long_halves: assert property (is_mull |=> wb.we_hi && wb.data_hi == $past(mull_res[63:32]))
        else $error("Long high half wrong");
    a_load_pc: assert property (is_load_pc |=> redirect && redirect_target == $past(load_data))
        else $error("Load to PC missed");

    // ****************************************************************
    // Checks on results against plain operators, plus flag, exchange and refusal checks
    // ****************************************************************
    // Kept apart from the shared adder (the CMN overflow check reads alu_res), so a slip in its muxing shows
    sequence s_long_unsigned;
        is_mull && !issue.mul_signed;
    endsequence
    a_add_result: assert property (dp_write && opcode == OP_ADD
        |=> wb.data_lo == $past(op_a) + $past(op_b))
        else $error("Add result wrong");
    a_adc_result: assert property (dp_write && opcode == OP_ADC
        |=> wb.data_lo == $past(op_a) + $past(op_b) + {31'h0, $past(flags.c)})
        else $error("Add with carry wrong");
    a_sub_result: assert property (dp_write && opcode == OP_SUB
        |=> wb.data_lo == $past(op_a) - $past(op_b))
        else $error("Subtract result wrong");
    a_sbc_result: assert property (dp_write && opcode == OP_SBW
        |=> wb.data_lo == $past(op_a) - $past(op_b) - {31'h0, !$past(flags.c)})
        else $error("Subtract with borrow wrong");
    a_rsb_result: assert property (dp_write && opcode == OP_RSUB
        |=> wb.data_lo == $past(op_b) - $past(op_a))
        else $error("Reverse subtract wrong");
    a_rsc_result: assert property (dp_write && opcode == OP_RSBW
        |=> wb.data_lo == $past(op_b) - $past(op_a) - {31'h0, !$past(flags.c)})
        else $error("Reverse borrow wrong");
    a_bic_result: assert property (dp_write && opcode == OP_BIC
        |=> wb.data_lo == ($past(op_a) & ~$past(op_b)))
        else $error("Bit clear wrong");
    a_mvn_result: assert property (dp_write && opcode == OP_MVN
        |=> wb.data_lo == ~$past(op_b))
        else $error("Move inverted wrong");
    a_test_flags: assert property (is_data && opcode == OP_TST
        |=> !wb.we_lo && current_status_word.z == (($past(op_a) & $past(op_b)) == 32'h0))
        else $error("Bit test flags wrong");
    a_imm_operand: assert property (dp_write && opcode == OP_MOV && issue.insn[BIT_IMM_SEL]
        |=> wb.data_lo == $past(issue.op_imm))
        else $error("Immediate not selected");
    a_cmp_sets_z: assert property (is_data && opcode == OP_CMP
        |=> current_status_word.z == ($past(op_a) == $past(op_b)))
        else $error("Compare left flags");
    a_cmp_carry: assert property (is_data && opcode == OP_CMP
        |=> current_status_word.c == ($past(op_a) >= $past(op_b)))
        else $error("Compare carry wrong");
    a_logic_carry: assert property (dp_flags && !is_arith
        |=> current_status_word.c == $past(shifter_c))
        else $error("Logical carry wrong");
    a_cmn_overflow: assert property (is_data && opcode == OP_CMN
        |=> current_status_word.v == ($past(op_a[31]) == $past(op_b[31]) && $past(op_a[31]) != $past(alu_res[31])))
        else $error("Overflow flag wrong");
    a_mul_low: assert property (is_mul
        |=> wb.data_lo == $past(issue.op_first) * $past(issue.op_shift)
            + ($past(issue.mul_acc) ? $past(issue.op_acc_lo) : 32'h0))
        else $error("Multiply low word wrong");
    a_mul_keeps_cv: assert property (is_mul
        |=> current_status_word.c == $past(flags.c) && current_status_word.v == $past(flags.v))
        else $error("Multiply touched C or V");
    a_long_accum: assert property (s_long_unsigned
        |=> {wb.data_hi, wb.data_lo} == {32'h0, $past(issue.op_first)} * {32'h0, $past(issue.op_shift)}
            + ($past(issue.mul_acc) ? {$past(issue.op_acc_hi), $past(issue.op_acc_lo)} : 64'h0))
        else $error("Long accumulate wrong");
    a_long_negative: assert property (is_mull && set_bit
        |=> current_status_word.n == wb.data_hi[31])
        else $error("Long negative flag wrong");
    a_exch_target: assert property (is_exch
        |=> redirect && redirect_target == {$past(issue.op_shift[31:1]), 1'b0})
        else $error("Exchange target wrong");
    a_exch_mode: assert property (is_exch
        |=> compact_mode == $past(issue.op_shift[0]))
        else $error("Exchange mode wrong");
    a_refused_idle: assert property (s_failed_cond
        |=> !executed)
        else $error("Refused op executed");
endmodule : branch_alu_multiply_exec

/* File: tb/regfile_model.sv */
`timescale 1ns/1ns
module regfile_model
    import exec_pkg::*;
(
    input wire logic clk,
    input wire wb_s wb
);
    // ****************************************************************
    // Register file behind the decode stage
    // ****************************************************************
    // Hi port written last, so it wins when both halves hit one register
    logic [31:0] regs [16];
    always_ff @(posedge clk) begin
        if (wb.we_lo) begin
            regs[wb.rd_lo] <= wb.data_lo;
        end
        if (wb.we_hi) begin
            regs[wb.rd_hi] <= wb.data_hi;
        end
    end
endmodule : regfile_model

/* File: tb/test_branch_alu_multiply_exec.sv */
`timescale 1ns/1ns
module test_branch_alu_multiply_exec
    import exec_pkg::*;
;
    typedef struct packed {
        logic [3:0] op;
        logic s;
        logic [31:0] a;
        logic [31:0] b;
        logic sc;
        logic [31:0] res;
        logic [3:0] f;
        logic we;
    } row_s;
    // Expected pass pattern of codes 0..14 with N=1 Z=0 C=0 V=1
    localparam logic [14:0] COND_PASS = 15'b101011001011010;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    issue_s issue = '0;
    logic [31:0] load_data = '0;
    wb_s wb;
    flags_s status;
    logic compact_mode;
    logic redirect;
    logic [31:0] redirect_target;
    logic executed;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    row_s rows [17];
    issue_s x;

    always #5 clk = ~clk;

    branch_alu_multiply_exec i_dut (.clk(clk), .rst_n(rst_n), .issue(issue), .load_data(load_data), .wb(wb),
        .current_status_word(status), .compact_mode(compact_mode), .redirect(redirect),
        .redirect_target(redirect_target), .executed(executed));
    regfile_model i_regs (.clk(clk), .wb(wb));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] dp(input logic [3:0] cc, input logic [3:0] op, input logic s, input logic i);
        return {cc, 2'b00, i, op, s, 20'h0};
    endfunction : dp

    function automatic issue_s mk(input kind_e k, input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b);
        issue_s r;
        r = '0;
        r.valid = 1'b1;
        r.kind = 3'(k);
        r.insn = ins;
        r.pc = 32'h1000;
        r.op_first = a;
        r.op_shift = b;
        r.rd = 4'h3;
        r.rd_hi = 4'h4;
        return r;
    endfunction : mk

    task automatic issue_op(input issue_s r);
        @(posedge clk);
        #1 issue = r;
        @(posedge clk);
        #1 issue.valid = 1'b0;
    endtask : issue_op

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_flags(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flags

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // Whole run is under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            final_report;
        end
    end

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        rows = '{'{OP_ADD, 1'b1, 32'hFFFFFFFF, 32'h1, 1'b0, 32'h0, 4'h6, 1'b1},
            '{OP_ADC, 1'b1, 32'h1, 32'h1, 1'b0, 32'h3, 4'h0, 1'b1},
            '{OP_SUB, 1'b1, 32'h5, 32'h7, 1'b0, 32'hFFFFFFFE, 4'h8, 1'b1},
            '{OP_SBW, 1'b1, 32'hA, 32'h3, 1'b0, 32'h6, 4'h2, 1'b1},
            '{OP_RSUB, 1'b1, 32'h1, 32'h80000000, 1'b0, 32'h7FFFFFFF, 4'h3, 1'b1},
            '{OP_AND, 1'b1, 32'hF0F0F0F0, 32'hFF00FF00, 1'b0, 32'hF000F000, 4'h9, 1'b1},
            '{OP_RSBW, 1'b1, 32'h3, 32'h9, 1'b0, 32'h5, 4'h2, 1'b1},
            '{OP_XOR, 1'b1, 32'hFFFF0000, 32'hFFFF0000, 1'b1, 32'h0, 4'h6, 1'b1},
            '{OP_OR, 1'b1, 32'h12340000, 32'h5678, 1'b0, 32'h12345678, 4'h0, 1'b1},
            '{OP_BIC, 1'b1, 32'hFFFFFFFF, 32'hFFFF, 1'b1, 32'hFFFF0000, 4'hA, 1'b1},
            '{OP_MOV, 1'b1, 32'h55, 32'h0, 1'b0, 32'h0, 4'h4, 1'b1},
            '{OP_MVN, 1'b1, 32'h55, 32'h0, 1'b1, 32'hFFFFFFFF, 4'hA, 1'b1},
            '{OP_TST, 1'b0, 32'hF, 32'hF0, 1'b0, 32'h0, 4'h4, 1'b0},
            '{OP_TEQ, 1'b0, 32'h80000000, 32'h0, 1'b1, 32'h0, 4'hA, 1'b0},
            '{OP_CMP, 1'b0, 32'h3, 32'h3, 1'b0, 32'h0, 4'h6, 1'b0},
            '{OP_CMN, 1'b0, 32'h7FFFFFFF, 32'h1, 1'b0, 32'h0, 4'h9, 1'b0},
            '{OP_ADD, 1'b0, 32'h2, 32'h3, 1'b0, 32'h5, 4'h9, 1'b1}};
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk_flags("flags_rst", 4'h0, status);
        chk_bit("redirect_rst", 1'b0, redirect);
        chk_bit("compact_rst", 1'b0, compact_mode);
        $display("test reset done");
        for (int i = 0; i < 17; i++) begin
            x = mk(K_DATA, dp(CC_AL, rows[i].op, rows[i].s, 1'b0), rows[i].a, rows[i].b);
            x.shift_carry = rows[i].sc;
            issue_op(x);
            chk_bit("we_lo", rows[i].we, wb.we_lo);
            chk_word("data_lo", rows[i].res, wb.data_lo);
            chk_flags("flags", rows[i].f, status);
        end
        $display("test data rows done");
        // Flags now N=1 Z=0 C=0 V=1; a move without S keeps them
        for (int c = 0; c < 16; c++) begin
            issue_op(mk(K_DATA, dp(4'(c), OP_MOV, 1'b0, 1'b0), 32'h0, 32'h7));
            chk_bit("executed", (c < 15) ? COND_PASS[c] : 1'b0, executed);
            chk_bit("cond_we", (c < 15) ? COND_PASS[c] : 1'b0, wb.we_lo);
        end
        $display("test conditions done");
        x = mk(K_MUL, dp(CC_AL, 4'h0, 1'b1, 1'b0), 32'hFFFFFFFF, 32'h3);
        x.mul_acc = 1'b1;
        x.op_acc_lo = 32'h5;
        issue_op(x);
        chk_word("mul_lo", 32'h2, wb.data_lo);
        chk_flags("mul_flags", 4'h1, status);
        x = mk(K_MUL_LONG, dp(CC_AL, 4'h0, 1'b1, 1'b0), 32'hFFFFFFFF, 32'h3);
        x.mul_signed = 1'b1;
        issue_op(x);
        chk_word("smul_lo", 32'hFFFFFFFD, wb.data_lo);
        chk_word("smul_hi", 32'hFFFFFFFF, wb.data_hi);
        chk_flags("smul_flags", 4'h9, status);
        x = mk(K_MUL_LONG, dp(CC_AL, 4'h0, 1'b0, 1'b0), 32'hFFFFFFFF, 32'h3);
        x.mul_acc = 1'b1;
        x.op_acc_lo = 32'h3;
        x.op_acc_hi = 32'h1;
        issue_op(x);
        chk_word("umla_lo", 32'h0, wb.data_lo);
        chk_word("umla_hi", 32'h4, wb.data_hi);
        chk_flags("umla_rd_hi", 4'h4, wb.rd_hi);
        $display("test multiply done");
        issue_op(mk(K_BRANCH, {CC_AL, 3'b101, 1'b1, 24'hFFFFFE}, 32'h0, 32'h0));
        chk_bit("b_redirect", 1'b1, redirect);
        chk_word("b_target", 32'h00000FF8, redirect_target);
        chk_flags("link_rd", 4'hE, wb.rd_lo);
        chk_word("link_data", 32'h00001004, wb.data_lo);
        issue_op(mk(K_EXCHANGE, dp(CC_AL, 4'h0, 1'b0, 1'b0), 32'h0, 32'h00002001));
        chk_word("x_target", 32'h00002000, redirect_target);
        chk_bit("x_compact", 1'b1, compact_mode);
        chk_word("link_reg", 32'h00001004, i_regs.regs[14]);
        load_data = 32'h00040000;
        issue_op(mk(K_LOAD_PC, dp(CC_AL, 4'h0, 1'b0, 1'b0), 32'h0, 32'h0));
        chk_word("ld_target", 32'h00040000, redirect_target);
        chk_flags("ld_rd", 4'hF, wb.rd_lo);
        $display("test flow done");
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        chk_flags("flags_rst2", 4'h0, status);
        chk_bit("compact_rst2", 1'b0, compact_mode);
        x = mk(K_DATA, dp(CC_AL, OP_MOV, 1'b0, 1'b0), 32'h0, 32'h00000400);
        x.rd = 4'hF;
        issue_op(x);
        chk_bit("pc_redirect", 1'b1, redirect);
        chk_word("pc_target", 32'h00000400, redirect_target);
        x = mk(K_DATA, dp(CC_AL, OP_MOV, 1'b0, 1'b1), 32'h0, 32'h7);
        x.op_imm = 32'h00000ABC;
        issue_op(x);
        chk_word("imm_data", 32'h00000ABC, wb.data_lo);
        $display("test reset and pc write done");
        final_report;
    end
endmodule : test_branch_alu_multiply_exec
